// File: logic/dcr_pkg.sv
// Package with register map, field positions and codes of the channel.
package dcr_pkg;
    localparam logic [4:0] ADDR_CTRL   = 5'h00;
    localparam logic [4:0] ADDR_MODE   = 5'h01;
    localparam logic [4:0] ADDR_SSA_L  = 5'h02;
    localparam logic [4:0] ADDR_SSA_H  = 5'h03;
    localparam logic [4:0] ADDR_SSA_U  = 5'h04;
    localparam logic [4:0] ADDR_SOURCE_POINTER_L = 5'h05;
    localparam logic [4:0] ADDR_SOURCE_POINTER_H = 5'h06;
    localparam logic [4:0] ADDR_SOURCE_POINTER_U = 5'h07;
    localparam logic [4:0] ADDR_SSZ_L  = 5'h08;
    localparam logic [4:0] ADDR_SSZ_H  = 5'h09;
    localparam logic [4:0] ADDR_SOURCE_COUNT_L = 5'h0a;
    localparam logic [4:0] ADDR_SOURCE_COUNT_H = 5'h0b;
    localparam logic [4:0] ADDR_DSA_L  = 5'h0c;
    localparam logic [4:0] ADDR_DSA_H  = 5'h0d;
    localparam logic [4:0] ADDR_DEST_POINTER_L = 5'h0e;
    localparam logic [4:0] ADDR_DEST_POINTER_H = 5'h0f;
    localparam logic [4:0] ADDR_DSZ_L  = 5'h10;
    localparam logic [4:0] ADDR_DSZ_H  = 5'h11;
    localparam logic [4:0] ADDR_DEST_COUNT_L = 5'h12;
    localparam logic [4:0] ADDR_DEST_COUNT_H = 5'h13;
    localparam logic [4:0] ADDR_TSEL   = 5'h14;
    // Control register bits.
    localparam int CTRL_EN_BIT   = 7;
    localparam int CTRL_HWEN_BIT = 6;
    localparam int CTRL_GO_BIT   = 5;
    // Mode register fields.
    localparam int MODE_DEST_ADDR_MODE_LSB = 6;
    localparam int MODE_DEST_RELOAD_STOP_BIT  = 5;
    localparam int MODE_SRC_ADDR_MODE_LSB = 1;
    localparam int MODE_SSTP_BIT  = 0;
    localparam int SRC_AW  = 22;
    localparam int DST_AW  = 16;
    localparam int CNT_W   = 12;
    localparam int SEL_W   = 7;
    localparam int NTRIG   = 128;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    typedef enum logic [1:0] {
        DCR_AM_HOLD = 2'b00,
        DCR_AM_INC  = 2'b01,
        DCR_AM_DEC  = 2'b10,
        DCR_AM_RSV  = 2'b11
    } dcr_amode_e;
    typedef enum logic [1:0] {
        DCR_ST_IDLE = 2'b00,
        DCR_ST_READ = 2'b01,
        DCR_ST_WRITE = 2'b10
    } dcr_state_e;
endpackage

// File: logic/dcr_side.sv
// One side of the channel: address pointer and byte counter.
`timescale 1ns/1ps
module dcr_side #(
    parameter int AW = 16
) (
    input  wire logic                     i_clk,
    input  wire logic                     i_reset,
    input  wire logic                     i_load,
    input  wire logic                     i_step,
    input  wire logic [1:0]               i_mode,
    input  wire logic [AW-1:0]            i_start,
    input  wire logic [dcr_pkg::CNT_W-1:0] i_size,
    output logic      [AW-1:0]            o_ptr,
    output logic      [dcr_pkg::CNT_W-1:0] o_count,
    output logic                          o_last
);
    import dcr_pkg::*;
    typedef struct packed {
        logic [AW-1:0]    ptr;
        logic [CNT_W-1:0] cnt;
    } dcr_side_s;
    dcr_side_s s_q;
    dcr_side_s s_d;

    // A size of zero behaves as one byte so the counter never wraps.
    assign o_last  = (s_q.cnt <= CNT_W'(1));
    assign o_ptr   = s_q.ptr;
    assign o_count = s_q.cnt;

    always_comb begin
        s_d = s_q;
        if (i_load) begin
            s_d.ptr = i_start; // RULE15
            s_d.cnt = i_size;
        end else if (i_step) begin
            if (o_last) begin
                s_d.ptr = i_start; // RULE14
                s_d.cnt = i_size;
            end else begin
                s_d.cnt = s_q.cnt - CNT_W'(1); // RULE14
                unique case (dcr_amode_e'(i_mode))
                    DCR_AM_INC: s_d.ptr = s_q.ptr + AW'(1); // RULE10 RULE11
                    DCR_AM_DEC: s_d.ptr = s_q.ptr - AW'(1);
                    DCR_AM_HOLD, DCR_AM_RSV: s_d.ptr = s_q.ptr;
                endcase
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule // dcr_side

// File: logic/dcr_trig.sv
// Start trigger picker with rising-edge detection.
`timescale 1ns/1ps
module dcr_trig (
    input  wire logic                     i_clk,
    input  wire logic                     i_reset,
    input  wire logic [dcr_pkg::NTRIG-1:0] i_trig,
    input  wire logic [dcr_pkg::SEL_W-1:0] i_sel,
    output logic                          o_fire
);
    import dcr_pkg::*;
    typedef struct packed {
        logic lvl;
        logic fire;
    } dcr_trig_s;
    dcr_trig_s t_q;
    dcr_trig_s t_d;

    assign o_fire = t_q.fire;

    // Selector code zero is reserved, so it never fires.
    always_comb begin
        t_d = t_q;
        t_d.lvl  = (i_sel != '0) && i_trig[i_sel]; // RULE8
        t_d.fire = t_d.lvl && !t_q.lvl;
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            t_q <= '0;
        end else begin
            t_q <= t_d;
        end
    end
endmodule // dcr_trig

// File: logic/dcr_chan.sv
// One transfer channel: register file, sequencer and bus requests.
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
// Summary of operation
// RULE1: Source pointer bits 21:16 read in upper register bits 5-0, 7-6 zero.
// RULE2: Source size is 12 bits writable over two registers, reset zero.
// RULE3: Source byte count reads as low byte plus high nibble, zero at reset.
// RULE4: Destination start address is 16 bits writable, reset zero.
// RULE5: Destination pointer reads as two read-only bytes, zero at reset.
// RULE6: Destination size is 12 bits writable, high register bits 7-4 zero.
// RULE7: Destination byte count reads as low byte plus high nibble.
// RULE8: Seven-bit trigger selector picks the hardware start source.
// RULE9: Unimplemented bits read zero and ignore writes.
// RULE10: Destination pointer holds, increments or decrements per transfer.
// RULE11: Source pointer holds, increments or decrements per transfer.
// RULE12: Hardware trigger starts transfers only when start enable is set.
// RULE13: Destination reload clears start enable when reload stop is set.
// RULE14: Counters count down per byte and reload with pointer at zero.
// RULE15: Enabling the channel loads pointers and counters before transfers.
module dcr_chan (
    input  wire logic                      i_clk,
    input  wire logic                      i_reset,
    input  wire logic [4:0]                i_addr,
    input  wire logic [7:0]                i_wdata,
    input  wire logic                      i_wr,
    input  wire logic                      i_rd,
    output logic      [7:0]                o_rdata,
    input  wire logic [dcr_pkg::NTRIG-1:0]  i_trig,
    output logic                           o_rd_req,
    output logic      [dcr_pkg::SRC_AW-1:0] o_rd_addr,
    input  wire logic                      i_rd_ack,
    input  wire logic [7:0]                i_rd_data,
    output logic                           o_wr_req,
    output logic      [dcr_pkg::DST_AW-1:0] o_wr_addr,
    output logic      [7:0]                o_wr_data,
    input  wire logic                      i_wr_ack,
    output logic                           o_busy
);
    import dcr_pkg::*;

    typedef struct packed {
        dcr_state_e        st;
        logic              en;
        logic              hwen;
        logic              go;
        logic [1:0]        dest_addr_mode;
        logic              dest_reload_stop;
        logic [1:0]        src_addr_mode;
        logic              sstp;
        logic [SRC_AW-1:0] ssa;
        logic [CNT_W-1:0]  source_size;
        logic [DST_AW-1:0] dest_start;
        logic [CNT_W-1:0]  dest_size;
        logic [SEL_W-1:0]  sel;
        logic [7:0]        buf_byte;
        logic              src_end;
        logic              load;
        logic [7:0]        rdata;
        logic              rd_req;
        logic              wr_req;
    } dcr_chan_s;
    dcr_chan_s c_q;
    dcr_chan_s c_d;

    logic [SRC_AW-1:0] source_pointer;
    logic [CNT_W-1:0]  source_count;
    logic              s_last;
    logic [DST_AW-1:0] dest_pointer;
    logic [CNT_W-1:0]  dest_count;
    logic              d_last;
    logic              trig_fire;
    logic              s_step;
    logic              d_step;

    assign s_step = (c_q.st == DCR_ST_READ) && i_rd_ack;
    assign d_step = (c_q.st == DCR_ST_WRITE) && i_wr_ack;

    dcr_side #(.AW(SRC_AW)) u_src (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_load  (c_q.load),
        .i_step  (s_step),
        .i_mode  (c_q.src_addr_mode),
        .i_start (c_q.ssa),
        .i_size  (c_q.source_size),
        .o_ptr   (source_pointer),
        .o_count (source_count),
        .o_last  (s_last)
    );

    dcr_side #(.AW(DST_AW)) u_dst (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_load  (c_q.load),
        .i_step  (d_step),
        .i_mode  (c_q.dest_addr_mode),
        .i_start (c_q.dest_start),
        .i_size  (c_q.dest_size),
        .o_ptr   (dest_pointer),
        .o_count (dest_count),
        .o_last  (d_last)
    );

    dcr_trig u_trig (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_trig  (i_trig),
        .i_sel   (c_q.sel),
        .o_fire  (trig_fire)
    );

    assign o_rdata   = c_q.rdata;
    assign o_rd_req  = c_q.rd_req;
    assign o_rd_addr = source_pointer;
    assign o_wr_req  = c_q.wr_req;
    assign o_wr_addr = dest_pointer;
    assign o_wr_data = c_q.buf_byte;
    assign o_busy    = c_q.go;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        c_d = c_q;
        c_d.load = 1'b0;
        c_d.rdata = RESET_BYTE;
        // Register writes; bits above each field are dropped.
        if (i_wr) begin // RULE9
            unique case (i_addr)
                ADDR_CTRL: begin
                    c_d.en   = i_wdata[CTRL_EN_BIT];
                    c_d.hwen = i_wdata[CTRL_HWEN_BIT];
                    c_d.go   = c_q.go | i_wdata[CTRL_GO_BIT];
                    c_d.load = i_wdata[CTRL_EN_BIT] && !c_q.en; // RULE15
                end
                ADDR_MODE: begin
                    c_d.dest_addr_mode = i_wdata[MODE_DEST_ADDR_MODE_LSB +: 2];
                    c_d.dest_reload_stop  = i_wdata[MODE_DEST_RELOAD_STOP_BIT];
                    c_d.src_addr_mode = i_wdata[MODE_SRC_ADDR_MODE_LSB +: 2];
                    c_d.sstp  = i_wdata[MODE_SSTP_BIT];
                end
                ADDR_SSA_L: c_d.ssa[7:0]   = i_wdata;
                ADDR_SSA_H: c_d.ssa[15:8]  = i_wdata;
                ADDR_SSA_U: c_d.ssa[21:16] = i_wdata[5:0];
                ADDR_SSZ_L: c_d.source_size[7:0]   = i_wdata; // RULE2
                ADDR_SSZ_H: c_d.source_size[11:8]  = i_wdata[3:0]; // RULE2
                ADDR_DSA_L: c_d.dest_start[7:0]   = i_wdata; // RULE4
                ADDR_DSA_H: c_d.dest_start[15:8]  = i_wdata; // RULE4
                ADDR_DSZ_L: c_d.dest_size[7:0]   = i_wdata; // RULE6
                ADDR_DSZ_H: c_d.dest_size[11:8]  = i_wdata[3:0]; // RULE6
                ADDR_TSEL:  c_d.sel = i_wdata[SEL_W-1:0]; // RULE8
                default: ;
            endcase
        end
        // Read data stands only in the cycle after the strobe.
        if (i_rd) begin
            unique case (i_addr)
                ADDR_CTRL: c_d.rdata = {c_q.en, c_q.hwen, c_q.go, 5'h00};
                ADDR_MODE: c_d.rdata = {c_q.dest_addr_mode, c_q.dest_reload_stop, 2'h0,
                                        c_q.src_addr_mode, c_q.sstp};
                ADDR_SSA_L:  c_d.rdata = c_q.ssa[7:0];
                ADDR_SSA_H:  c_d.rdata = c_q.ssa[15:8];
                ADDR_SSA_U:  c_d.rdata = {2'h0, c_q.ssa[21:16]};
                ADDR_SOURCE_POINTER_L: c_d.rdata = source_pointer[7:0];
                ADDR_SOURCE_POINTER_H: c_d.rdata = source_pointer[15:8];
                ADDR_SOURCE_POINTER_U: c_d.rdata = {2'h0, source_pointer[21:16]}; // RULE1
                ADDR_SSZ_L:  c_d.rdata = c_q.source_size[7:0];
                ADDR_SSZ_H:  c_d.rdata = {4'h0, c_q.source_size[11:8]};
                ADDR_SOURCE_COUNT_L: c_d.rdata = source_count[7:0]; // RULE3
                ADDR_SOURCE_COUNT_H: c_d.rdata = {4'h0, source_count[11:8]}; // RULE3
                ADDR_DSA_L:  c_d.rdata = c_q.dest_start[7:0];
                ADDR_DSA_H:  c_d.rdata = c_q.dest_start[15:8];
                ADDR_DEST_POINTER_L: c_d.rdata = dest_pointer[7:0]; // RULE5
                ADDR_DEST_POINTER_H: c_d.rdata = dest_pointer[15:8]; // RULE5
                ADDR_DSZ_L:  c_d.rdata = c_q.dest_size[7:0];
                ADDR_DSZ_H:  c_d.rdata = {4'h0, c_q.dest_size[11:8]};
                ADDR_DEST_COUNT_L: c_d.rdata = dest_count[7:0]; // RULE7
                ADDR_DEST_COUNT_H: c_d.rdata = {4'h0, dest_count[11:8]}; // RULE7
                ADDR_TSEL:   c_d.rdata = {1'b0, c_q.sel};
                default:     c_d.rdata = RESET_BYTE;
            endcase
        end
        // A trigger landing with a software write of go is kept.
        if (c_q.en && c_q.hwen && trig_fire) begin
            c_d.go = 1'b1; // RULE12
        end
        ////////////////////////////////////////////////////////////////////
        unique case (c_q.st)
            DCR_ST_IDLE: begin
                // Wait one cycle after enable so the load lands first.
                if (c_q.en && c_q.go && !c_q.load) begin
                    c_d.st = DCR_ST_READ;
                    c_d.rd_req = 1'b1;
                    c_d.src_end = 1'b0;
                end
            end
            DCR_ST_READ: begin
                if (i_rd_ack) begin
                    c_d.buf_byte = i_rd_data;
                    c_d.src_end = s_last;
                    c_d.rd_req = 1'b0;
                    c_d.wr_req = 1'b1;
                    c_d.st = DCR_ST_WRITE;
                    // A software write of the control register wins.
                    if (s_last && c_q.sstp &&
                        !(i_wr && i_addr == ADDR_CTRL)) begin
                        c_d.hwen = 1'b0;
                    end
                end
            end
            DCR_ST_WRITE: begin
                if (i_wr_ack) begin
                    c_d.wr_req = 1'b0;
                    if (d_last && c_q.dest_reload_stop &&
                        !(i_wr && i_addr == ADDR_CTRL)) begin
                        c_d.hwen = 1'b0; // RULE13
                    end
                    // A reload on either side ends the transaction; a new
                    // start landing in the same cycle is kept.
                    if (d_last || c_q.src_end || !c_q.en) begin
                        c_d.go = (i_wr && i_addr == ADDR_CTRL &&
                                  i_wdata[CTRL_GO_BIT]) ||
                                 (c_q.en && c_q.hwen && trig_fire);
                        c_d.st = DCR_ST_IDLE;
                    end else begin
                        c_d.rd_req = 1'b1;
                        c_d.st = DCR_ST_READ;
                    end
                end
            end
            default: begin
                c_d.st = DCR_ST_IDLE;
                c_d.rd_req = 1'b0;
                c_d.wr_req = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            c_q <= '0;
        end else begin
            c_q <= c_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking dcr_cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    a_upper_zero_read: assert property ( // RULE1
        i_rd && i_addr == ADDR_SOURCE_POINTER_U |=> o_rdata == {2'h0, source_pointer[21:16]})
        else $error("source pointer upper read wrong");
    a_ssz_high_read: assert property ( // RULE2
        i_wr && i_addr == ADDR_SSZ_H ##1 i_rd && i_addr == ADDR_SSZ_H
        |=> o_rdata == {4'h0, $past(i_wdata[3:0], 2)})
        else $error("source size high readback wrong");
    a_dest_count_high_read: assert property ( // RULE7
        i_rd && i_addr == ADDR_DEST_COUNT_H |=> o_rdata[7:4] == 4'h0)
        else $error("dest count high upper nibble not zero");
    a_sel_written: assert property ( // RULE8
        i_wr && i_addr == ADDR_TSEL |=> c_q.sel == $past(i_wdata[6:0]))
        else $error("trigger selector not written");
    a_dest_pointer_inc_step: assert property ( // RULE10
        d_step && !d_last && c_q.dest_addr_mode == 2'b01
        |=> dest_pointer == $past(dest_pointer) + 16'h0001)
        else $error("dest pointer did not increment");
    a_dest_pointer_dec_step: assert property ( // RULE10
        d_step && !d_last && c_q.dest_addr_mode == 2'b10
        |=> dest_pointer == $past(dest_pointer) - 16'h0001)
        else $error("dest pointer did not decrement");
    a_source_pointer_hold_step: assert property ( // RULE11
        s_step && !s_last && c_q.src_addr_mode == 2'b00 |=> $stable(source_pointer))
        else $error("source pointer moved in hold mode");
    a_hw_start_gate: assert property ( // RULE12
        c_q.st == DCR_ST_IDLE && !c_q.go && !c_q.hwen && !i_wr
        |=> !c_q.go)
        else $error("transfer started without enable");
    a_stop_clears: assert property ( // RULE13
        d_step && d_last && c_q.dest_reload_stop && !i_wr |=> !c_q.hwen)
        else $error("start enable not cleared on dest reload");
    a_source_count_down: assert property ( // RULE14
        s_step && !s_last |=> source_count == $past(source_count) - 12'h001)
        else $error("source count did not count down");
    a_enable_load: assert property ( // RULE15
        i_wr && i_addr == ADDR_CTRL && i_wdata[7] && !c_q.en
        |=> ##1 dest_count == c_q.dest_size && dest_pointer == c_q.dest_start && !o_rd_req)
        else $error("enable did not load pointers and counts");
endmodule // dcr_chan

// File: test/dcr_mem_model.sv
// System bus memory model answering the channel's byte reads and writes.
`timescale 1ns/1ps
module dcr_mem_model (
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic [3:0]  i_wait,
    input  wire logic        i_rd_req,
    input  wire logic [21:0] i_rd_addr,
    output logic             o_rd_ack,
    output logic      [7:0]  o_rd_data,
    input  wire logic        i_wr_req,
    input  wire logic [15:0] i_wr_addr,
    input  wire logic [7:0]  i_wr_data,
    output logic             o_wr_ack
);
    logic [3:0]  cnt_q;
    logic [7:0]  last_q;
    logic [15:0] log_addr [8];
    logic [7:0]  log_data [8];
    int          n_log;

    // Outside an answer the data lines show the inverse of the last byte,
    // so a channel that samples at the wrong edge catches a wrong value.
    assign o_rd_data = o_rd_ack ? last_q : ~last_q;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            cnt_q    <= 4'h0;
            last_q   <= 8'h00;
            o_rd_ack <= 1'b0;
            o_wr_ack <= 1'b0;
            n_log    <= 0;
        end else begin
            o_rd_ack <= 1'b0;
            o_wr_ack <= 1'b0;
            if (i_wr_req && o_wr_ack) begin
                log_addr[n_log % 8] <= i_wr_addr;
                log_data[n_log % 8] <= i_wr_data;
                n_log <= n_log + 1;
            end
            if ((i_rd_req && !o_rd_ack) || (i_wr_req && !o_wr_ack)) begin
                if (cnt_q >= i_wait) begin
                    cnt_q <= 4'h0;
                    if (i_rd_req) begin
                        o_rd_ack <= 1'b1;
                        last_q   <= i_rd_addr[7:0];
                    end else begin
                        o_wr_ack <= 1'b1;
                    end
                end else begin
                    cnt_q <= cnt_q + 4'h1;
                end
            end
        end
    end
endmodule // dcr_mem_model

// File: test/dcr_testbench.sv
// Register and transfer tests of one channel against the memory model.
`timescale 1ns/1ps
module testbench;
    import dcr_pkg::*;
    logic         i_clk, i_reset, i_wr, i_rd, rd_ack, wr_ack;
    logic         rd_req, wr_req, busy;
    logic [4:0]   i_addr;
    logic [7:0]   i_wdata, rdata, rd_data, wr_data;
    logic [127:0] i_trig;
    logic [21:0]  rd_addr;
    logic [15:0]  wr_addr;
    logic [3:0]   mem_wait;
    logic [7:0]   got;
    int           miscompares, n_checks;
    logic [4:0]   regs [14] = '{ADDR_SOURCE_POINTER_U, ADDR_SSZ_L, ADDR_SSZ_H,
        ADDR_SOURCE_COUNT_L, ADDR_SOURCE_COUNT_H, ADDR_DSA_L, ADDR_DSA_H, ADDR_DEST_POINTER_L,
        ADDR_DEST_POINTER_H, ADDR_DSZ_L, ADDR_DSZ_H, ADDR_DEST_COUNT_L, ADDR_DEST_COUNT_H,
        ADDR_TSEL};

    dcr_chan dut (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(rdata),
        .i_trig(i_trig), .o_rd_req(rd_req), .o_rd_addr(rd_addr),
        .i_rd_ack(rd_ack), .i_rd_data(rd_data), .o_wr_req(wr_req),
        .o_wr_addr(wr_addr), .o_wr_data(wr_data), .i_wr_ack(wr_ack),
        .o_busy(busy));
    dcr_mem_model mem (.i_clk(i_clk), .i_reset(i_reset), .i_wait(mem_wait),
        .i_rd_req(rd_req), .i_rd_addr(rd_addr), .o_rd_ack(rd_ack),
        .o_rd_data(rd_data), .i_wr_req(wr_req), .i_wr_addr(wr_addr),
        .i_wr_data(wr_data), .o_wr_ack(wr_ack));

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] seen);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd   <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
        rd(a, got);
        chk($sformatf("register %h", a), {24'h0, exp}, {24'h0, got});
    endtask

    task automatic wait_idle();
        int i;
        repeat (2) @(posedge i_clk);
        #1;
        for (i = 0; i < 300 && busy !== 1'b0; i++) begin
            @(posedge i_clk);
            #1;
        end
        chk("busy at end", 32'h0, {31'h0, busy});
    endtask

    task automatic trig_pulse(input int n);
        @(posedge i_clk);
        i_trig[n] <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_trig[n] <= 1'b0;
        repeat (6) @(posedge i_clk);
    endtask

    task automatic results();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #20000;
        miscompares++;
        results();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        i_reset = 1'b1; i_wr = 1'b0; i_rd = 1'b0; i_addr = 5'h00;
        i_wdata = 8'h00; i_trig = '0; mem_wait = 4'h0;
        repeat (3) @(posedge i_clk);
        i_reset <= 1'b0;
        // Every register of the table reads zero after reset.
        foreach (regs[i]) rd_chk(regs[i], 8'h00);
        // Unimplemented bits drop writes, read-only places ignore them.
        wr(ADDR_SSZ_H, 8'hff);
        wr(ADDR_DSZ_H, 8'hff);
        wr(ADDR_TSEL, 8'hff);
        wr(ADDR_SOURCE_POINTER_U, 8'hff);
        wr(ADDR_SOURCE_COUNT_L, 8'hff);
        wr(ADDR_DEST_POINTER_H, 8'hff);
        wr(5'h1f, 8'hff);
        rd_chk(ADDR_SSZ_H, 8'h0f);
        rd_chk(ADDR_DSZ_H, 8'h0f);
        rd_chk(ADDR_TSEL, 8'h7f);
        rd_chk(ADDR_SOURCE_POINTER_U, 8'h00);
        rd_chk(ADDR_SOURCE_COUNT_L, 8'h00);
        rd_chk(ADDR_DEST_POINTER_H, 8'h00);
        rd_chk(5'h1f, 8'h00);
        // Software transfer: source decrements, destination increments.
        wr(ADDR_SSA_L, 8'h10);
        wr(ADDR_SSA_H, 8'h20);
        wr(ADDR_SSA_U, 8'h3f);
        wr(ADDR_SSZ_L, 8'h02);
        wr(ADDR_SSZ_H, 8'h00);
        wr(ADDR_DSZ_L, 8'h03);
        wr(ADDR_DSZ_H, 8'h00);
        wr(ADDR_DSA_L, 8'h00);
        wr(ADDR_DSA_H, 8'h10);
        rd_chk(ADDR_DSA_H, 8'h10);
        rd_chk(ADDR_SSZ_L, 8'h02);
        wr(ADDR_MODE, 8'h44);
        wr(ADDR_CTRL, 8'h80);
        rd_chk(ADDR_SOURCE_POINTER_U, 8'h3f);
        rd_chk(ADDR_SOURCE_COUNT_L, 8'h02);
        rd_chk(ADDR_DEST_POINTER_H, 8'h10);
        rd_chk(ADDR_DEST_COUNT_L, 8'h03);
        mem_wait <= 4'h3;
        wr(ADDR_CTRL, 8'ha0);
        wait_idle();
        chk("bytes moved", 32'd2, mem.n_log);
        chk("write 0 addr", 32'h1000, {16'h0, mem.log_addr[0]});
        chk("write 0 data", 32'h10, {24'h0, mem.log_data[0]});
        chk("write 1 addr", 32'h1001, {16'h0, mem.log_addr[1]});
        chk("write 1 data", 32'h0f, {24'h0, mem.log_data[1]});
        rd_chk(ADDR_SOURCE_COUNT_L, 8'h02);
        rd_chk(ADDR_SOURCE_COUNT_H, 8'h00);
        rd_chk(ADDR_DEST_COUNT_L, 8'h01);
        rd_chk(ADDR_DEST_COUNT_H, 8'h00);
        rd_chk(ADDR_DEST_POINTER_L, 8'h02);
        rd_chk(ADDR_SOURCE_POINTER_L, 8'h10);
        // Hardware start: gated by the start enable bit and by the selector.
        mem_wait <= 4'h0;
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_SSZ_L, 8'h04);
        wr(ADDR_DSZ_L, 8'h01);
        wr(ADDR_DSA_H, 8'h20);
        wr(ADDR_MODE, 8'h22);
        wr(ADDR_TSEL, 8'h05);
        wr(ADDR_CTRL, 8'h80);
        trig_pulse(5);
        chk("busy hw disabled", 32'h0, {31'h0, busy});
        wr(ADDR_CTRL, 8'hc0);
        trig_pulse(6);
        chk("busy other source", 32'h0, {31'h0, busy});
        chk("bytes before trig", 32'd2, mem.n_log);
        trig_pulse(5);
        wait_idle();
        chk("bytes after trig", 32'd3, mem.n_log);
        chk("write 2 addr", 32'h2000, {16'h0, mem.log_addr[2]});
        chk("write 2 data", 32'h10, {24'h0, mem.log_data[2]});
        rd_chk(ADDR_CTRL, 8'h80);
        rd_chk(ADDR_SOURCE_COUNT_L, 8'h03);
        rd_chk(ADDR_SOURCE_POINTER_L, 8'h11);
        rd_chk(ADDR_DEST_POINTER_H, 8'h20);
        results();
    end
endmodule // testbench
